// ===== banked_data_memory_addressing.sv
// Banked data memory addressing: address forming, bank pointer and data storage
`timescale 1ns/100ps
`default_nettype none
`include "bank_addr_regs.svh"

module banked_data_memory_addressing
	import bank_addr_pkg::*;
#(
	parameter int BANKS_IMPL = 16,
	parameter logic [15:0] FUNC_IMPL_MASK = 16'h0003
)
(
	// Clock and reset
	input wire logic clk_sys_in,
	input wire logic rst_in,
	// Decoder side
	input wire mem_req_t req_in,
	input wire logic load_bank_literal_in,
	input wire logic [7:0] bank_literal_in,
	input wire logic extended_set_enable_in,
	input wire logic [11:0] alt_access_addr_in,
	// Function register read data from outside, taken in the request cycle for the decoded address
	input wire logic [7:0] func_rdata_in,
	// Results
	output mem_rsp_t rsp_out,
	output logic [3:0] bank_select_reg_out,
	output logic pc_low_write_out,
	output logic [7:0] pc_low_data_out,
	output logic func_write_out
);

	localparam int GP_BYTES = 3968;

	// General locations: no reset, so contents survive every reset
	logic [7:0] gp_mem [0:GP_BYTES-1];

	logic [3:0] bank_select_reg_q, bank_select_reg_d;
	mem_rsp_t rsp_q, rsp_d;
	logic pcw_q, pcw_d;
	logic [7:0] pcd_q, pcd_d;
	logic fw_q, fw_d;
	acc_state_t state_q, state_d;
	logic [11:0] eff_addr;
	logic impl_bank;
	logic is_func;
	logic [7:0] rd_byte;
	logic gp_we;
	logic rsp_due;

	// Forms the 12-bit address from the request
	function automatic logic [11:0] form_addr(input mem_req_t r, input logic [3:0] bank,
		input logic ext, input logic [11:0] alt);
		logic [11:0] a;
		a = 12'h000;
		if (r.full_addr)
			a = r.addr_full;
		else if (r.access_sel)
			a = {bank, r.operand};
		else if (ext)
			a = alt;
		else if (r.operand < `ACCESS_SPLIT)
			a = {4'h0, r.operand};
		else
			a = {`TOP_BANK, r.operand};
		return a;
	endfunction : form_addr

	// Address decode; bank count is a parameter so a smaller part can be modelled
	always_comb
	begin
		eff_addr = form_addr(req_in, bank_select_reg_q, extended_set_enable_in,
			alt_access_addr_in);
		is_func = (eff_addr >= `FUNC_REGION_BASE);
		impl_bank = (32'(eff_addr[11:8]) < BANKS_IMPL) || is_func;
		gp_we = req_in.valid && req_in.write && impl_bank && !is_func;
	end

	// Read data selection
	always_comb
	begin
		rd_byte = 8'h00;
		if (!impl_bank)
			rd_byte = 8'h00;
		else if (eff_addr == `BANK_POINTER_ADDR)
			rd_byte = {4'h0, bank_select_reg_q};
		else if (is_func)
			rd_byte = FUNC_IMPL_MASK[eff_addr[3:0]] ? func_rdata_in : 8'h00;
		else
			rd_byte = gp_mem[eff_addr];
	end

	// Memory write; no reset on purpose
	always_ff @(posedge clk_sys_in)
	begin
		if (gp_we)
			gp_mem[eff_addr] <= req_in.wdata;
	end

	// Next state of pointer, response and side strobes
	always_comb
	begin
		bank_select_reg_d = bank_select_reg_q;
		rsp_d = '0;
		pcw_d = 1'b0;
		pcd_d = pcd_q;
		fw_d = 1'b0;
		state_d = ST_IDLE;
		if (load_bank_literal_in)
			bank_select_reg_d = bank_literal_in[`BANK_FIELD_MSB:0];
		if (req_in.valid)
		begin
			// One cycle per access, forced or banked
			state_d = ST_DONE;
			rsp_d.valid = 1'b1;
			rsp_d.addr = eff_addr;
			// Flags come from data moved even when the bank is absent
			rsp_d.rdata = req_in.write ? req_in.wdata : rd_byte;
			rsp_d.zero = (rsp_d.rdata == 8'h00);
			rsp_d.negative = rsp_d.rdata[7];
			if (req_in.write && eff_addr == `BANK_POINTER_ADDR)
				bank_select_reg_d = req_in.wdata[`BANK_FIELD_MSB:0];
			if (req_in.write && eff_addr == `PC_LOW_ADDR)
			begin
				pcw_d = 1'b1;
				pcd_d = req_in.wdata;
			end
			fw_d = req_in.write && is_func;
		end
	end

	// State registers
	always_ff @(posedge clk_sys_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			bank_select_reg_q <= `BANK_POINTER_RESET;
			rsp_q <= '0;
			pcw_q <= 1'b0;
			pcd_q <= 8'h00;
			fw_q <= 1'b0;
			state_q <= ST_IDLE;
		end
		else
		begin
			bank_select_reg_q <= bank_select_reg_d;
			rsp_q <= rsp_d;
			pcw_q <= pcw_d;
			pcd_q <= pcd_d;
			fw_q <= fw_d;
			state_q <= state_d;
		end
	end

	assign rsp_out = rsp_q;
	assign bank_select_reg_out = bank_select_reg_q;
	assign pc_low_write_out = pcw_q;
	assign pc_low_data_out = pcd_q;
	assign func_write_out = fw_q;

	// Access phase decode; the answer stands only in the cycle after a request
	always_comb
	begin
		rsp_due = 1'b0;
		case (state_q)
			ST_IDLE:
				rsp_due = 1'b0;
			ST_DONE:
				rsp_due = 1'b1;
			default:
				rsp_due = 1'b0;
		endcase
	end

	// Assertions
	// Any accepted request
	sequence s_req;
		req_in.valid;
	endsequence

	// Banked request, bank pointer on top of the operand
	sequence s_banked_req;
		req_in.valid && !req_in.full_addr && req_in.access_sel;
	endsequence

	// Request through the standard access map
	sequence s_access_req;
		req_in.valid && !req_in.full_addr && !req_in.access_sel && !extended_set_enable_in;
	endsequence

	// Write that lands in the function register region
	sequence s_func_write;
		req_in.valid && req_in.write && is_func;
	endsequence

	// Every request is answered on the next edge
	a_single_cycle: assert property (@(posedge clk_sys_in) disable iff (rst_in)
		s_req |=> rsp_out.valid)
		else $error("access not answered in one cycle");

	// No answer without a request
	a_no_spurious: assert property (@(posedge clk_sys_in) disable iff (rst_in)
		!req_in.valid |=> !rsp_out.valid)
		else $error("answer without request");

	// Banked address is pointer then operand
	a_banked_addr: assert property (@(posedge clk_sys_in) disable iff (rst_in)
		s_banked_req |=> rsp_out.addr == {$past(bank_select_reg_q), $past(req_in.operand)})
		else $error("banked address wrong");

	// Full address move passes its own address
	a_full_addr: assert property (@(posedge clk_sys_in) disable iff (rst_in)
		req_in.valid && req_in.full_addr |=> rsp_out.addr == $past(req_in.addr_full))
		else $error("full address move wrong");

	// Lower map half lands in bank 0
	a_access_low: assert property (@(posedge clk_sys_in) disable iff (rst_in)
		s_access_req ##0 (req_in.operand < `ACCESS_SPLIT)
		|=> rsp_out.addr == {4'h0, $past(req_in.operand)})
		else $error("access low half wrong");

	// Upper map half lands in the top bank, pointer ignored
	a_access_high: assert property (@(posedge clk_sys_in) disable iff (rst_in)
		s_access_req ##0 (req_in.operand >= `ACCESS_SPLIT)
		|=> rsp_out.addr == {`TOP_BANK, $past(req_in.operand)})
		else $error("access high half wrong");

	// Extended set swaps in the outside map
	a_alt_map: assert property (@(posedge clk_sys_in) disable iff (rst_in)
		req_in.valid && !req_in.full_addr && !req_in.access_sel && extended_set_enable_in
		|=> rsp_out.addr == $past(alt_access_addr_in))
		else $error("alternate access map wrong");

	// Literal load reaches the pointer
	a_literal_load: assert property (@(posedge clk_sys_in) disable iff (rst_in)
		load_bank_literal_in && !req_in.valid
		|=> bank_select_reg_out == $past(bank_literal_in[`BANK_FIELD_MSB:0]))
		else $error("literal load wrong");

	// Data write to the pointer keeps only the low bits
	a_ptr_write: assert property (@(posedge clk_sys_in) disable iff (rst_in)
		req_in.valid && req_in.write && eff_addr == `BANK_POINTER_ADDR
		|=> bank_select_reg_out == $past(req_in.wdata[`BANK_FIELD_MSB:0]))
		else $error("pointer write wrong");

	// Pointer reads back with its upper bits zero
	a_ptr_read: assert property (@(posedge clk_sys_in) disable iff (rst_in)
		req_in.valid && !req_in.write && eff_addr == `BANK_POINTER_ADDR
		|=> rsp_out.rdata == {4'h0, $past(bank_select_reg_q)})
		else $error("pointer read wrong");

	// Pointer holds unless loaded or written
	a_ptr_hold: assert property (@(posedge clk_sys_in) disable iff (rst_in)
		!load_bank_literal_in && !(req_in.valid && req_in.write && eff_addr == `BANK_POINTER_ADDR)
		|=> $stable(bank_select_reg_out))
		else $error("pointer changed on its own");

	// Banked write to the program counter low byte
	a_pc_write: assert property (@(posedge clk_sys_in) disable iff (rst_in)
		s_banked_req ##0 (req_in.write && {bank_select_reg_q, req_in.operand} == `PC_LOW_ADDR)
		|=> pc_low_write_out && pc_low_data_out == $past(req_in.wdata))
		else $error("program counter low write missed");

	// Zero flag follows the moved byte
	a_flags: assert property (@(posedge clk_sys_in) disable iff (rst_in)
		rsp_out.valid |-> rsp_out.zero == (rsp_out.rdata == 8'h00))
		else $error("zero flag wrong");

	// Negative flag follows the moved byte
	a_flag_negative: assert property (@(posedge clk_sys_in) disable iff (rst_in)
		rsp_out.valid |-> rsp_out.negative == rsp_out.rdata[7])
		else $error("negative flag wrong");

	// Writes report their data even when dropped
	a_write_echo: assert property (@(posedge clk_sys_in) disable iff (rst_in)
		req_in.valid && req_in.write |=> rsp_out.rdata == $past(req_in.wdata))
		else $error("write data not reported");

	// Absent banks read zero
	a_unimpl_read: assert property (@(posedge clk_sys_in) disable iff (rst_in)
		req_in.valid && !req_in.write && !impl_bank |=> rsp_out.rdata == 8'h00)
		else $error("absent bank not zero");

	// Unused function locations read zero
	a_unused_func: assert property (@(posedge clk_sys_in) disable iff (rst_in)
		req_in.valid && !req_in.write && is_func && eff_addr != `BANK_POINTER_ADDR
		&& !FUNC_IMPL_MASK[eff_addr[3:0]] |=> rsp_out.rdata == 8'h00)
		else $error("unused function location not zero");

	// Function region writes are strobed out
	a_func_write: assert property (@(posedge clk_sys_in) disable iff (rst_in)
		s_func_write |=> func_write_out)
		else $error("function write strobe missed");

	// No strobe for anything else
	a_func_quiet: assert property (@(posedge clk_sys_in) disable iff (rst_in)
		!(req_in.valid && req_in.write && is_func) |=> !func_write_out)
		else $error("function write strobe spurious");

	// Access phase and answer agree
	a_state_match: assert property (@(posedge clk_sys_in) disable iff (rst_in)
		rsp_due == rsp_out.valid)
		else $error("access phase out of step");

endmodule : banked_data_memory_addressing
`default_nettype wire

// ===== bank_addr_regs.svh
// Address map, field positions and reset values for the banked data memory addressing block
`ifndef BANK_ADDR_REGS_SVH
`define BANK_ADDR_REGS_SVH

// Bank pointer register address in the function register region
`define BANK_POINTER_ADDR 12'hFE0
// Program counter low byte address
`define PC_LOW_ADDR 12'hFF9
// Start of the function register region
`define FUNC_REGION_BASE 12'hF80
// Top bank number, holding the function register region
`define TOP_BANK 4'hF
// Split point of the access bank map
`define ACCESS_SPLIT 8'h80
// Bank pointer reset value
`define BANK_POINTER_RESET 4'h0
// Implemented bank pointer bits
`define BANK_FIELD_MSB 3

`endif

// ===== bank_addr_pkg.sv
// Types shared by the banked data memory addressing block
package bank_addr_pkg;

	// One data memory request from the instruction decoder
	typedef struct packed {
		logic valid;
		logic write;
		logic full_addr;
		logic access_sel;
		logic [11:0] addr_full;
		logic [7:0] operand;
		logic [7:0] wdata;
	} mem_req_t;

	// Result of one data memory access
	typedef struct packed {
		logic valid;
		logic [11:0] addr;
		logic [7:0] rdata;
		logic zero;
		logic negative;
	} mem_rsp_t;

	// Access state
	typedef enum logic [0:0] {
		ST_IDLE,
		ST_DONE
	} acc_state_t;

endpackage : bank_addr_pkg

// ===== func_regs_model.sv
// Stand-in for the function register read data of the peripherals
`timescale 1ns/100ps
`default_nettype none

module func_regs_model
#(
	parameter logic [7:0] FUNC_VALUE = 8'hB7
)
(
	// Read data toward the addressing block
	output logic [7:0] func_rdata_out
);
	// Constant value; its top bit set so the negative flag is seen
	assign func_rdata_out = FUNC_VALUE;
endmodule : func_regs_model
`default_nettype wire

// ===== tb_top.sv
// Self-checking bench for the banked data memory addressing block
`timescale 1ns/100ps
`default_nettype none
`include "bank_addr_regs.svh"

module tb_top;
	import bank_addr_pkg::*;
	typedef struct packed {logic [11:0] a; logic [7:0] d; logic p; logic w;} note_t;
	logic clk_sys_in = 1'b0;
	logic rst_in = 1'b1;
	logic lbl = 1'b0;
	logic xen = 1'b0;
	logic [7:0] lit = 8'h00;
	logic [7:0] fdat;
	logic [7:0] pcd;
	logic [7:0] op;
	logic [7:0] d;
	logic [3:0] bank_pointer;
	logic pcw;
	logic fw;
	mem_req_t req_in = '0;
	mem_rsp_t rsp_out;
	note_t q[$];
	note_t n;
	int miscompares = 0;
	int checks_done = 0;

	// Free-running core clock
	always #4 clk_sys_in = ~clk_sys_in;

	func_regs_model func_regs_model_i (.func_rdata_out(fdat));

	// Only eight banks present, so bank 9 is unimplemented
	banked_data_memory_addressing #(.BANKS_IMPL(8)) banked_data_memory_addressing_i (
		.clk_sys_in(clk_sys_in), .rst_in(rst_in), .req_in(req_in),
		.load_bank_literal_in(lbl), .bank_literal_in(lit),
		.extended_set_enable_in(xen), .alt_access_addr_in(12'h1A4),
		.func_rdata_in(fdat), .rsp_out(rsp_out), .bank_select_reg_out(bank_pointer),
		.pc_low_write_out(pcw), .pc_low_data_out(pcd), .func_write_out(fw));

	task chk(input logic [31:0] s, input logic [31:0] e);
		checks_done++;
		if (s !== e)
		begin
			miscompares++;
			$display("unexpected at %0t: saw %h want %h", $time, s, e);
		end
	endtask : chk

	task test_done;
		$display("checks %0d miscompares %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : test_done

	// One access per call; valid stays up so calls run back to back
	task acc(input logic w, f, a, input logic [11:0] fa, input logic [7:0] o, wd,
		input logic [11:0] ea, input logic [7:0] ed, input logic ep);
		@(negedge clk_sys_in);
		req_in = {1'b1, w, f, a, fa, o, wd};
		q.push_back({ea, ed, ep, w});
	endtask : acc

	// Drops any request before pulsing the literal load
	task ldb(input logic [7:0] v, input logic [3:0] e);
		@(negedge clk_sys_in);
		req_in.valid = 1'b0;
		lbl = 1'b1;
		lit = v;
		@(negedge clk_sys_in);
		lbl = 1'b0;
		chk(bank_pointer, e);
	endtask : ldb

	// Result watcher, after the edge's updates have landed
	always @(posedge clk_sys_in)
	begin
		#1;
		if (rsp_out.valid === 1'b1)
		begin
			n = q.pop_front();
			chk(rsp_out.addr, n.a);
			chk(rsp_out.rdata, n.d);
			chk({rsp_out.zero, rsp_out.negative}, {n.d == 8'h00, n.d[7]});
			chk(pcw, n.p);
			chk(fw, n.w && n.a >= `FUNC_REGION_BASE);
			if (n.p)
				chk(pcd, n.d);
		end
	end

	// Main sequence
	initial
	begin
		void'($urandom(21));
		repeat (5) @(posedge clk_sys_in);
		@(negedge clk_sys_in);
		rst_in = 1'b0;
		chk(bank_pointer, 4'h0);
		ldb(8'hF3, 4'h3);
		acc(1, 0, 1, 0, 8'h12, 8'hC4, 12'h312, 8'hC4, 0);
		acc(0, 0, 1, 0, 8'h12, 0, 12'h312, 8'hC4, 0);
		acc(1, 1, 1, 12'h7A5, 8'h12, 0, 12'h7A5, 8'h00, 0);
		acc(0, 1, 0, 12'h7A5, 8'h12, 0, 12'h7A5, 8'h00, 0);
		// Low map half ignores the bank pointer of 3
		repeat (4)
		begin
			op = 8'($urandom_range(0, 127));
			d = 8'($urandom);
			acc(1, 0, 0, 0, op, d, {4'h0, op}, d, 0);
			acc(0, 0, 0, 0, op, 0, {4'h0, op}, d, 0);
		end
		acc(0, 0, 0, 0, 8'h90, 0, 12'hF90, 8'hB7, 0);
		acc(0, 0, 0, 0, 8'h92, 0, 12'hF92, 8'h00, 0);
		// Pointer written through its own address; upper bits read back zero
		acc(1, 1, 0, 12'hFE0, 8'h00, 8'hA5, 12'hFE0, 8'hA5, 0);
		acc(0, 1, 0, 12'hFE0, 8'h00, 0, 12'hFE0, 8'h05, 0);
		ldb(8'h09, 4'h9);
		acc(1, 0, 1, 0, 8'h40, 8'h81, 12'h940, 8'h81, 0);
		acc(0, 0, 1, 0, 8'h40, 0, 12'h940, 8'h00, 0);
		ldb(8'h0F, 4'hF);
		acc(1, 0, 1, 0, 8'hF9, 8'h2E, 12'hFF9, 8'h2E, 1);
		// Mid-run reset: pointer clears, general locations keep their data
		@(negedge clk_sys_in);
		req_in.valid = 1'b0;
		rst_in = 1'b1;
		repeat (2) @(negedge clk_sys_in);
		rst_in = 1'b0;
		chk(bank_pointer, 4'h0);
		acc(0, 1, 0, 12'h312, 8'h00, 0, 12'h312, 8'hC4, 0);
		xen = 1'b1;
		acc(1, 0, 0, 0, 8'h10, 8'h66, 12'h1A4, 8'h66, 0);
		acc(0, 0, 0, 0, 8'h10, 0, 12'h1A4, 8'h66, 0);
		@(negedge clk_sys_in);
		req_in.valid = 1'b0;
		repeat (3) @(negedge clk_sys_in);
		chk(q.size(), 0);
		test_done();
	end

	// Watchdog well past the expected run length
	initial
	begin
		#20000;
		miscompares++;
		test_done();
	end
endmodule : tb_top
`default_nettype wire
